// [src/psm_pkg.sv]
// package for the power supply mode controller: constants, types, states
// assumes one 50 MHz clock domain and no register bus
// Overview of operation
// - power-on reset leaves converter bypassed, unregulated
// - input comparator bit high when supply low
// - warmup about 100 us then open bypass
// - running flag set when changeover completes
// - in-regulation flag set when output regulated
// - run/idle uses first settings, sleep second
// - shutoff refused while active, error flag set
// - pmic core bit disables internal core regulators
// - pmic irq falling edge sets flag when pmic drives a supply, enable gates irq
// - pmic irq input works in all modes
// - direct mode drives both lines push-pull, no pullups
// - line levels run 11, sleep 01, shutoff 00, start 10
// - run and shutoff always pass through sleep
// - tripped detector requests reset; overvoltage trips high
// - digital detector on in run/idle only, DET_LE detector always enabled
// - settle masks 20 us core and overvoltage, 100 us others
package psm_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ        = 50;
  localparam int WARMUP_US      = 100;
  localparam int SETTLE_CORE_US = 20;
  localparam int SETTLE_LONG_US = 100;
  localparam int WARMUP_CYC      = WARMUP_US * CLK_MHZ;
  localparam int SETTLE_CORE_CYC = SETTLE_CORE_US * CLK_MHZ;
  localparam int SETTLE_LONG_CYC = SETTLE_LONG_US * CLK_MHZ;
  localparam int CNT_W           = 13;
  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int IPK_W  = 4;
  localparam int DRV_W  = 2;
  localparam int NDET   = 6;
  // detector index
  localparam int DET_DIG  = 0;
  localparam int DET_LE   = 1;
  localparam int DET_CORE = 2;
  localparam int DET_OV   = 3;
  localparam int DET_ANA  = 4;
  localparam int DET_IO   = 5;
  localparam logic [1:0] LINES_RUN   = 2'h3;
  localparam logic [1:0] LINES_SLEEP = 2'h1;
  localparam logic [1:0] LINES_OFF   = 2'h0;
  localparam logic [1:0] LINES_START = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PSM_MODE_RUN   = 2'h0,
    PSM_MODE_IDLE  = 2'h1,
    PSM_MODE_SLEEP = 2'h2,
    PSM_MODE_OFF   = 2'h3
  } psm_mode_t;

  typedef enum logic [3:0] {
    CV_BYPASS  = 4'h1,
    CV_WARMUP  = 4'h2,
    CV_RUNNING = 4'h4,
    CV_REGOK   = 4'h8
  } psm_cv_state_t;

  typedef enum logic [3:0] {
    DS_RUN   = 4'h1,
    DS_SLEEP = 4'h2,
    DS_OFF   = 4'h4,
    DS_START = 4'h8
  } psm_ds_state_t;

  typedef struct packed {
    logic [IPK_W-1:0] peak_current_setting;
    logic [DRV_W-1:0] driver_speed_setting;
  } psm_tune_t;
endpackage

// [src/psm_ctrl.sv]
// power supply mode controller: converter sequencing, pmic pins, detectors
// assumes analogue comparators arrive asynchronously; software drives controls
module psm_ctrl (
  // clock, enable, reset
  input  wire logic                  clk,
  input  wire logic                  clk_en,
  input  wire logic                  reset,
  // converter control
  input  wire logic                  converter_enable,
  input  wire logic                  regulate_mode,
  input  wire psm_pkg::psm_tune_t    tune_run,
  input  wire psm_pkg::psm_tune_t    tune_sleep,
  input  wire logic [4:0]            peak_detect_max_time,
  input  wire logic [1:0]            input_threshold_select,
  input  wire logic                  input_comparator_enable,
  input  wire logic                  input_below_raw,
  input  wire logic                  output_regulated_raw,
  // energy mode request
  input  wire psm_pkg::psm_mode_t    mode_request,
  input  wire logic                  start_request,
  // flag clears, one-cycle pulses
  input  wire logic                  clr_running,
  input  wire logic                  clr_regulation,
  input  wire logic                  clr_input_low,
  input  wire logic                  clr_shutoff_err,
  input  wire logic                  clr_pmic,
  // converter status
  output logic                       bypass_on,
  output logic                       regulation_on,
  output logic                       input_below_threshold,
  output logic [1:0]                 threshold_to_analog,
  output logic                       comparator_on,
  output psm_pkg::psm_tune_t         tune_applied,
  output logic [4:0]                 peak_time_applied,
  output logic                       converter_running_flag,
  output logic                       in_regulation_flag,
  output logic                       input_low_flag,
  output logic                       shutoff_entry_error_flag,
  output psm_pkg::psm_mode_t         mode_now,
  // pmic
  input  wire logic                  pmic_drives_core_supply,
  input  wire logic                  pmic_drives_digital_supply,
  input  wire logic                  pmic_irq_enable,
  input  wire logic                  pmic_direct_mode_enable,
  input  wire logic                  pmic_irq_n_pin,
  input  wire logic                  i2c_scl_out,
  input  wire logic                  i2c_sda_out,
  output logic                       core_regulators_on,
  output logic                       pmic_flag,
  output logic                       pmic_irq,
  output logic                       scl_o,
  output logic                       scl_oe,
  output logic                       sda_o,
  output logic                       sda_oe,
  output logic                       i2c_pullup_en,
  // detectors
  input  wire logic [5:0]            detector_enable,
  input  wire logic [5:0]            detector_trip_raw,
  output logic [5:0]                 detector_active,
  output logic                       bod_reset_req
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [8:0] sync1_ff;
  logic [8:0] sync2_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      // idle levels: irq line released high, trips and comparators quiet,
      // so no false edge follows reset
      sync1_ff <= 9'h100;
      sync2_ff <= 9'h100;
    end else if (clk_en) begin
      sync1_ff <= {pmic_irq_n_pin, output_regulated_raw, input_below_raw, detector_trip_raw};
      sync2_ff <= sync1_ff;
    end
  end
  wire logic [5:0] trip_s   = sync2_ff[5:0];
  wire logic       below_s  = sync2_ff[6];
  wire logic       regok_s  = sync2_ff[7];
  wire logic       irq_n_s  = sync2_ff[8];

  // ****************************************************************
  // energy mode and shutoff refusal
  // ****************************************************************
  psm_pkg::psm_mode_t mode_ff;
  logic               conv_active;
  assign conv_active = converter_enable | regulation_on;
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= psm_pkg::PSM_MODE_RUN;
    end else if (clk_en) begin
      if (mode_request == psm_pkg::PSM_MODE_OFF && conv_active) begin
        mode_ff <= mode_ff;
      end else begin
        mode_ff <= mode_request;
      end
    end
  end
  assign mode_now = mode_ff;

  // ****************************************************************
  // converter sequencer
  // ****************************************************************
  psm_pkg::psm_cv_state_t cv_ff;
  psm_pkg::psm_cv_state_t nxt_cv;
  logic [psm_pkg::CNT_W-1:0] warm_ff;
  logic                      go_reg;
  assign go_reg = converter_enable & regulate_mode;
  always_comb begin
    nxt_cv = cv_ff;
    case (cv_ff)
      psm_pkg::CV_BYPASS:  if (go_reg) nxt_cv = psm_pkg::CV_WARMUP;
      psm_pkg::CV_WARMUP:  if (!go_reg) nxt_cv = psm_pkg::CV_BYPASS;
                           else if (warm_ff == '0) nxt_cv = psm_pkg::CV_RUNNING;
      psm_pkg::CV_RUNNING: if (!go_reg) nxt_cv = psm_pkg::CV_BYPASS;
                           else if (regok_s) nxt_cv = psm_pkg::CV_REGOK;
      psm_pkg::CV_REGOK:   if (!go_reg) nxt_cv = psm_pkg::CV_BYPASS;
      default:             nxt_cv = psm_pkg::CV_BYPASS;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cv_ff <= psm_pkg::CV_BYPASS;
    end else if (clk_en) begin
      cv_ff <= nxt_cv;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      warm_ff <= '0;
    end else if (clk_en) begin
      if (cv_ff == psm_pkg::CV_BYPASS) begin
        warm_ff <= psm_pkg::CNT_W'(psm_pkg::WARMUP_CYC - 1);
      end else if (warm_ff != '0) begin
        warm_ff <= warm_ff - 1'b1;
      end
    end
  end
  assign bypass_on     = (cv_ff == psm_pkg::CV_BYPASS) | (cv_ff == psm_pkg::CV_WARMUP);
  assign regulation_on = ~bypass_on;

  // ****************************************************************
  // comparator and tuning
  // ****************************************************************
  assign threshold_to_analog = input_threshold_select;
  assign comparator_on       = input_comparator_enable;
  logic below_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      below_ff <= 1'b0;
    end else if (clk_en) begin
      below_ff <= input_comparator_enable & below_s;
    end
  end
  assign input_below_threshold = below_ff;

  logic               sleepish;
  psm_pkg::psm_tune_t tune_ff;
  logic [4:0]         ptime_ff;
  assign sleepish = (mode_ff == psm_pkg::PSM_MODE_SLEEP) | (mode_ff == psm_pkg::PSM_MODE_OFF);
  always_ff @(posedge clk) begin
    if (reset) begin
      tune_ff  <= '0;
      ptime_ff <= '0;
    end else if (clk_en) begin
      tune_ff  <= sleepish ? tune_sleep : tune_run;
      ptime_ff <= peak_detect_max_time;
    end
  end
  assign tune_applied      = tune_ff;
  assign peak_time_applied = ptime_ff;

  // ****************************************************************
  // sticky flags: set wins over clear
  // ****************************************************************
  logic run_ff, regf_ff, low_ff, err_ff, pmic_ff, irq_n_d_ff;
  logic set_run, set_reg, set_low, set_err, set_pmic;
  assign set_run  = (cv_ff == psm_pkg::CV_WARMUP) & (nxt_cv == psm_pkg::CV_RUNNING);
  assign set_reg  = (cv_ff == psm_pkg::CV_RUNNING) & (nxt_cv == psm_pkg::CV_REGOK);
  assign set_low  = input_comparator_enable & below_s & ~below_ff;
  assign set_err  = (mode_request == psm_pkg::PSM_MODE_OFF) & conv_active
                    & (mode_ff != psm_pkg::PSM_MODE_OFF);
  assign set_pmic = (pmic_drives_core_supply | pmic_drives_digital_supply)
                    & irq_n_d_ff & ~irq_n_s;
  always_ff @(posedge clk) begin
    if (reset) begin
      run_ff  <= 1'b0;
      regf_ff <= 1'b0;
      low_ff  <= 1'b0;
      err_ff  <= 1'b0;
      pmic_ff <= 1'b0;
      irq_n_d_ff <= 1'b1;
    end else if (clk_en) begin
      run_ff  <= set_run  | (run_ff  & ~clr_running);
      regf_ff <= set_reg  | (regf_ff & ~clr_regulation);
      low_ff  <= set_low  | (low_ff  & ~clr_input_low);
      err_ff  <= set_err  | (err_ff  & ~clr_shutoff_err);
      pmic_ff <= set_pmic | (pmic_ff & ~clr_pmic);
      irq_n_d_ff <= irq_n_s;
    end
  end
  assign converter_running_flag   = run_ff;
  assign in_regulation_flag       = regf_ff;
  assign input_low_flag           = low_ff;
  assign shutoff_entry_error_flag = err_ff;
  assign pmic_flag                = pmic_ff;
  assign pmic_irq                 = pmic_ff & pmic_irq_enable;
  assign core_regulators_on       = ~pmic_drives_core_supply;

  // ****************************************************************
  // direct mode line states
  // ****************************************************************
  psm_pkg::psm_ds_state_t ds_ff;
  psm_pkg::psm_ds_state_t nxt_ds;
  always_comb begin
    nxt_ds = ds_ff;
    case (ds_ff)
      psm_pkg::DS_RUN:   if (start_request) nxt_ds = psm_pkg::DS_START;
                         else if (mode_ff == psm_pkg::PSM_MODE_SLEEP
                                  || mode_ff == psm_pkg::PSM_MODE_OFF) nxt_ds = psm_pkg::DS_SLEEP;
      psm_pkg::DS_SLEEP: if (mode_ff == psm_pkg::PSM_MODE_OFF) nxt_ds = psm_pkg::DS_OFF;
                         else if (mode_ff != psm_pkg::PSM_MODE_SLEEP) nxt_ds = psm_pkg::DS_RUN;
      psm_pkg::DS_OFF:   if (mode_ff != psm_pkg::PSM_MODE_OFF) nxt_ds = psm_pkg::DS_SLEEP;
      psm_pkg::DS_START: if (!start_request) nxt_ds = psm_pkg::DS_RUN;
      default:           nxt_ds = psm_pkg::DS_RUN;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ds_ff <= psm_pkg::DS_RUN;
    end else if (clk_en) begin
      ds_ff <= nxt_ds;
    end
  end
  logic [1:0] lines;
  always_comb begin
    case (ds_ff)
      psm_pkg::DS_SLEEP: lines = psm_pkg::LINES_SLEEP;
      psm_pkg::DS_OFF:   lines = psm_pkg::LINES_OFF;
      psm_pkg::DS_START: lines = psm_pkg::LINES_START;
      default:           lines = psm_pkg::LINES_RUN;
    endcase
  end
  // open drain outside direct mode: drive only the low level
  assign scl_o         = pmic_direct_mode_enable ? lines[1] : 1'b0;
  assign sda_o         = pmic_direct_mode_enable ? lines[0] : 1'b0;
  assign scl_oe        = pmic_direct_mode_enable | ~i2c_scl_out;
  assign sda_oe        = pmic_direct_mode_enable | ~i2c_sda_out;
  assign i2c_pullup_en = ~pmic_direct_mode_enable;

  // ****************************************************************
  // brown-out detectors
  // ****************************************************************
  logic [5:0] en_eff, en_d_ff;
  logic [psm_pkg::CNT_W-1:0] mask_ff [6];
  always_comb begin
    en_eff = detector_enable;
    en_eff[psm_pkg::DET_DIG] = ~sleepish;
    en_eff[psm_pkg::DET_LE]  = 1'b1;
  end
  function automatic logic [psm_pkg::CNT_W-1:0] settle_len(input int idx);
    if (idx == psm_pkg::DET_CORE || idx == psm_pkg::DET_OV)
      settle_len = psm_pkg::CNT_W'(psm_pkg::SETTLE_CORE_CYC);
    else
      settle_len = psm_pkg::CNT_W'(psm_pkg::SETTLE_LONG_CYC);
  endfunction
  always_ff @(posedge clk) begin
    if (reset) begin
      en_d_ff <= '0;
      for (int i = 0; i < 6; i++) mask_ff[i] <= '0;
    end else if (clk_en) begin
      en_d_ff <= en_eff;
      for (int i = 0; i < 6; i++) begin
        if (en_eff[i] && !en_d_ff[i]) mask_ff[i] <= settle_len(i);
        else if (mask_ff[i] != '0) mask_ff[i] <= mask_ff[i] - 1'b1;
      end
    end
  end
  logic [5:0] live;
  always_comb begin
    for (int i = 0; i < 6; i++) live[i] = en_d_ff[i] & (mask_ff[i] == '0);
  end
  assign detector_active = live;
  logic bod_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      bod_ff <= 1'b0;
    end else if (clk_en) begin
      bod_ff <= |(live & trip_s);
    end
  end
  assign bod_reset_req = bod_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence warm_start_s;
    clk_en && cv_ff == psm_pkg::CV_BYPASS && go_reg;
  endsequence
  reset_bypass_a: assert property ($fell(reset) |-> bypass_on) else $error("no bypass");
  warmup_len_a: assert property (warm_start_s ##1 (clk_en && go_reg)[*8] |-> bypass_on)
    else $error("bypass opened early");
  running_flag_a: assert property (clk_en && set_run |=> converter_running_flag)
    else $error("running flag missing");
  reg_flag_a: assert property (clk_en && set_reg |=> in_regulation_flag)
    else $error("regulation flag missing");
  off_refuse_a: assert property (clk_en && mode_request == psm_pkg::PSM_MODE_OFF && conv_active
    && mode_ff != psm_pkg::PSM_MODE_OFF |=> mode_ff != psm_pkg::PSM_MODE_OFF && err_ff)
    else $error("shutoff accepted while active");
  pmic_irq_a: assert property (pmic_irq |-> pmic_irq_enable && pmic_flag)
    else $error("pmic irq ungated");
  no_run_off_a: assert property (clk_en && ds_ff == psm_pkg::DS_RUN |=> ds_ff != psm_pkg::DS_OFF)
    else $error("run to shutoff direct");
  lines_off_a: assert property (ds_ff == psm_pkg::DS_OFF && pmic_direct_mode_enable
    |-> !scl_o && !sda_o && scl_oe && sda_oe) else $error("bad shutoff lines");
  pullup_a: assert property (pmic_direct_mode_enable |-> !i2c_pullup_en)
    else $error("pullup on in direct mode");
  bod_mask_a: assert property (clk_en && en_eff[psm_pkg::DET_CORE] && !en_d_ff[psm_pkg::DET_CORE]
    |=> !live[psm_pkg::DET_CORE] [*8]) else $error("core detector unmasked");
endmodule

// [tb/psm_pmic_model.sv]
// far-side power management chip: watches the retasked lines, drives irq
// assumes the bench resolves both lines, released lines read high
module psm_pmic_model (
  // clock
  input  wire logic clk,
  // line levels and direct mode qualifier
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic direct,
  // irq request from the bench
  input  wire logic pull_irq,
  output logic      irq_n,
  output int        bad_jumps
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] last_ff;
  // open drain: released line falls back to its pull-up level
  assign irq_n = pull_irq ? 1'b0 : 1'b1;
  initial begin
    bad_jumps = 0;
    last_ff = 2'h3;
  end
  // run and shutoff never meet without sleep in between
  always @(posedge clk) begin
    if (direct && ({last_ff, scl, sda} == 4'hc || {last_ff, scl, sda} == 4'h3))
      bad_jumps++;
    last_ff <= {scl, sda};
  end
endmodule

// [tb/psm_ctrl_tb.sv]
// testbench for psm_ctrl: software-side sequences with expected port values
// assumes psm_pmic_model as far side and a 50 MHz clock
module psm_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk, reset, converter_enable, regulate_mode, input_comparator_enable;
  logic input_below_raw, output_regulated_raw, start_request, pull_irq;
  logic clr_running, clr_regulation, clr_input_low, clr_shutoff_err, clr_pmic;
  logic pmic_drives_core_supply, pmic_irq_enable, pmic_direct_mode_enable;
  logic i2c_scl_out, i2c_sda_out, pmic_irq_n_pin, scl, sda;
  logic [4:0] peak_detect_max_time, peak_time_applied;
  logic [1:0] input_threshold_select, threshold_to_analog;
  logic [5:0] detector_enable, detector_trip_raw, detector_active;
  psm_pkg::psm_tune_t tune_run, tune_sleep, tune_applied;
  psm_pkg::psm_mode_t mode_request, mode_now;
  logic bypass_on, regulation_on, input_below_threshold, comparator_on;
  logic converter_running_flag, in_regulation_flag, input_low_flag;
  logic shutoff_entry_error_flag, core_regulators_on, pmic_flag, pmic_irq;
  logic scl_o, scl_oe, sda_o, sda_oe, i2c_pullup_en, bod_reset_req;
  int errors, check_count, bad_jumps, n;

  // bus pull-ups hold released lines high
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = sda_oe ? sda_o : 1'b1;
  initial clk = 1'b0;
  always #10 clk = ~clk;

  psm_ctrl i_dut (
    .clk(clk), .clk_en(1'b1), .reset(reset), .converter_enable(converter_enable),
    .regulate_mode(regulate_mode), .tune_run(tune_run), .tune_sleep(tune_sleep),
    .peak_detect_max_time(peak_detect_max_time), .input_threshold_select(input_threshold_select),
    .input_comparator_enable(input_comparator_enable), .input_below_raw(input_below_raw),
    .output_regulated_raw(output_regulated_raw), .mode_request(mode_request),
    .start_request(start_request), .clr_running(clr_running), .clr_regulation(clr_regulation),
    .clr_input_low(clr_input_low), .clr_shutoff_err(clr_shutoff_err), .clr_pmic(clr_pmic),
    .bypass_on(bypass_on), .regulation_on(regulation_on), .comparator_on(comparator_on),
    .input_below_threshold(input_below_threshold), .threshold_to_analog(threshold_to_analog),
    .tune_applied(tune_applied), .peak_time_applied(peak_time_applied),
    .converter_running_flag(converter_running_flag), .in_regulation_flag(in_regulation_flag),
    .input_low_flag(input_low_flag), .shutoff_entry_error_flag(shutoff_entry_error_flag),
    .mode_now(mode_now), .pmic_drives_core_supply(pmic_drives_core_supply),
    .pmic_drives_digital_supply(1'b0), .pmic_irq_enable(pmic_irq_enable),
    .pmic_direct_mode_enable(pmic_direct_mode_enable), .pmic_irq_n_pin(pmic_irq_n_pin),
    .i2c_scl_out(i2c_scl_out), .i2c_sda_out(i2c_sda_out), .pmic_irq(pmic_irq),
    .core_regulators_on(core_regulators_on), .pmic_flag(pmic_flag), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .i2c_pullup_en(i2c_pullup_en),
    .detector_enable(detector_enable), .detector_trip_raw(detector_trip_raw),
    .detector_active(detector_active), .bod_reset_req(bod_reset_req)
  );

  psm_pmic_model i_pmic (
    .clk(clk), .scl(scl), .sda(sda), .direct(pmic_direct_mode_enable),
    .pull_irq(pull_irq), .irq_n(pmic_irq_n_pin), .bad_jumps(bad_jumps)
  );

  // ****************************************************************
  // access tasks
  // ****************************************************************
  // waits k rising edges, then settles on the falling edge for sampling
  task automatic look(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: return regulation_on;
      1: return in_regulation_flag;
      2: return input_low_flag;
      3: return bypass_on;
      4: return pmic_flag;
      5: return bod_reset_req;
      default: return detector_active[4];
    endcase
  endfunction
  // n ends as the number of cycles the output took to reach val
  task automatic wait_for(input int sel, input logic val, input int lim);
    @(negedge clk);
    for (n = 0; n < lim && probe(sel) !== val; n++)
      @(negedge clk);
    if (n == lim) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      conclude();
    end
  endtask
  task automatic clr_all();
    @(posedge clk);
    {clr_running, clr_regulation, clr_input_low, clr_shutoff_err, clr_pmic} <= 5'h1f;
    @(posedge clk);
    {clr_running, clr_regulation, clr_input_low, clr_shutoff_err, clr_pmic} <= 5'h00;
  endtask
  task automatic go(input psm_pkg::psm_mode_t m);
    @(posedge clk) mode_request <= m;
    look(6);
  endtask
  task automatic do_reset();
    @(posedge clk) reset <= 1'b1;
    look(12);
    @(posedge clk) reset <= 1'b0;
    look(1);
    chk({bypass_on, regulation_on, converter_running_flag, bod_reset_req, input_low_flag, pmic_flag}, 8'h20);
    chk({mode_now, scl, sda}, 8'h03);
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    {errors, check_count} = {32'h0, 32'h0};
    {reset, converter_enable, regulate_mode, input_comparator_enable} = 4'h8;
    {input_below_raw, output_regulated_raw, start_request, pull_irq} = 4'h0;
    {clr_running, clr_regulation, clr_input_low, clr_shutoff_err, clr_pmic} = 5'h00;
    {pmic_drives_core_supply, pmic_irq_enable, pmic_direct_mode_enable} = 3'h0;
    {i2c_scl_out, i2c_sda_out, peak_detect_max_time, input_threshold_select} = 9'h1c2;
    {detector_enable, detector_trip_raw} = 12'h000;
    {tune_run, tune_sleep} = {4'h9, 2'h1, 4'h3, 2'h1};
    mode_request = psm_pkg::PSM_MODE_RUN;
    do_reset();
    // open drain pass-through before direct mode
    @(posedge clk) i2c_sda_out <= 1'b0;
    look(1);
    chk({sda_oe, sda_o, scl_oe, i2c_pullup_en}, 8'h09);
    @(posedge clk);
    {pmic_drives_core_supply, pmic_direct_mode_enable} <= 2'h3;
    {i2c_sda_out, input_comparator_enable} <= 2'h3;
    look(4);
    chk({core_regulators_on, i2c_pullup_en, scl_oe, sda_oe}, 8'h03);
    chk({scl, sda, input_below_threshold, comparator_on, threshold_to_analog}, 8'h36);
    // warmup then changeover; regulation reported separately
    @(posedge clk) converter_enable <= 1'b1;
    @(posedge clk) regulate_mode <= 1'b1;
    wait_for(0, 1'b1, 5100);
    chk(n >= psm_pkg::WARMUP_CYC - 2 && n <= psm_pkg::WARMUP_CYC + 3, 8'h01);
    chk({bypass_on, converter_running_flag, in_regulation_flag}, 8'h02);
    @(posedge clk) output_regulated_raw <= 1'b1;
    wait_for(1, 1'b1, 8);
    chk(tune_applied, tune_run);
    chk(peak_time_applied, 8'h10);
    go(psm_pkg::PSM_MODE_SLEEP);
    chk(tune_applied, tune_sleep);
    chk({scl, sda, detector_active[0]}, 8'h02);
    go(psm_pkg::PSM_MODE_RUN);
    chk(tune_applied, tune_run);
    // shutoff refused while the converter runs
    go(psm_pkg::PSM_MODE_OFF);
    chk({mode_now, shutoff_entry_error_flag, scl, sda}, 8'h07);
    @(posedge clk) mode_request <= psm_pkg::PSM_MODE_RUN;
    // input drop: software falls back to bypass at once
    @(posedge clk) input_below_raw <= 1'b1;
    wait_for(2, 1'b1, 8);
    chk(input_below_threshold, 8'h01);
    @(posedge clk) {converter_enable, regulate_mode, input_below_raw} <= 3'h0;
    wait_for(3, 1'b1, 8);
    chk(regulation_on, 8'h00);
    clr_all();
    look(2);
    chk({converter_running_flag, in_regulation_flag, input_low_flag}, 8'h00);
    chk(shutoff_entry_error_flag, 8'h00);
    go(psm_pkg::PSM_MODE_OFF);
    chk({mode_now, scl, sda}, {psm_pkg::PSM_MODE_OFF, 2'h0});
    chk(tune_applied, tune_sleep);
    // irq line keeps working in shutoff, enable gates the interrupt
    @(posedge clk) pull_irq <= 1'b1;
    wait_for(4, 1'b1, 8);
    chk(pmic_irq, 8'h00);
    @(posedge clk) {pmic_irq_enable, pull_irq} <= 2'h2;
    look(1);
    chk(pmic_irq, 8'h01);
    clr_all();
    look(2);
    chk({pmic_flag, pmic_irq}, 8'h00);
    go(psm_pkg::PSM_MODE_RUN);
    chk({scl, sda}, 8'h03);
    @(posedge clk) start_request <= 1'b1;
    look(4);
    chk({scl, sda}, 8'h02);
    @(posedge clk) start_request <= 1'b0;
    look(4);
    chk({scl, sda}, 8'h03);
    // core detector: masked while settling, then trip forces reset
    @(posedge clk) {detector_enable, detector_trip_raw} <= 12'h104;
    wait_for(5, 1'b1, 1100);
    chk(n >= psm_pkg::SETTLE_CORE_CYC - 2 && n <= psm_pkg::SETTLE_CORE_CYC + 6, 8'h01);
    @(posedge clk) detector_trip_raw <= 6'h00;
    do_reset();
    @(posedge clk) detector_enable <= 6'h14;
    wait_for(6, 1'b1, 5100);
    chk(n >= psm_pkg::SETTLE_LONG_CYC - 2 && n <= psm_pkg::SETTLE_LONG_CYC + 6, 8'h01);
    chk({detector_active[1:0], bod_reset_req}, 8'h06);
    chk(bad_jumps[7:0], 8'h00);
    conclude();
  end
endmodule
